// file: dwce_host.sv
// host controller model reading the three code pins
// assumes pins are registered levels on the same clock
`timescale 1ns/1ps
module dwce_host (
	input  wire logic       code_out_bit_a,
	input  wire logic       code_out_bit_b,
	input  wire logic       code_out_bit_c,
	input  wire logic       code_output_select,
	input  wire logic       warning_active,
	output logic      [2:0] pattern,
	output logic            pattern_valid
);
	// ====================================================================
	// one raw pattern, valid flag gated
	// raw pattern kept so the bench can see codes leak when disabled
	assign pattern       = {code_out_bit_a, code_out_bit_b, code_out_bit_c};
	assign pattern_valid = code_output_select & warning_active;
endmodule : dwce_host

// file: dwce_pkg.sv
// package for the drive warning code encoder
// assumes a 20 MHz system clock and no register bus
package dwce_pkg;
	// ====================================================================
	// clock and timing
	localparam int unsigned CLK_HZ           = 20000000;
	localparam int unsigned OPEN_PHASE_MS    = 1000;
	localparam int unsigned OPEN_PHASE_CYC   = (CLK_HZ / 1000) * OPEN_PHASE_MS;
	localparam int unsigned CONTACT_MISS_CYC = 16;
	// ====================================================================
	// widths and settings
	localparam int unsigned ERR_W            = 32;
	localparam int unsigned PCT_W            = 8;
	localparam int unsigned PCT_DIV          = 100;
	localparam logic        SEL_WARN_CODES   = 1'b1;
	localparam logic        DETECT_OFF       = 1'b1;
	// ====================================================================
	// code patterns, bit order {a,b,c}
	localparam logic [2:0]  CODE_POS_ERR     = 3'h7;
	localparam logic [2:0]  CODE_OVERLOAD    = 3'h3;
	localparam logic [2:0]  CODE_REGEN_DB    = 3'h5;
	localparam logic [2:0]  CODE_BATTERY     = 3'h1;
	localparam logic [2:0]  CODE_RESTART     = 3'h6;
	localparam logic [2:0]  CODE_UNDERVOLT   = 3'h0;
	localparam logic [2:0]  CODE_OVERTRAVEL  = 3'h4;
	localparam logic [2:0]  CODE_IDLE        = 3'h0;
	// ====================================================================
	// reset values
	localparam logic [2:0]  CODE_RST         = 3'h0;
endpackage : dwce_pkg

// file: dwce_top.sv
// drive warning code encoder: detects warnings, drives three code pins
// assumes condition inputs are levels from outside logic on other clocks
//
// Function
// (RULE1) position error over level*percent/100 raises warning, code all high
// (RULE2) with power on, servo-on error over its limit raises warning, all high
// (RULE3) overload warning before overload alarm, code low high high
// (RULE4) vibration detected as warning or alarm by switch, code low high high
// (RULE5) regenerative overload warning before alarm, code high low high
// (RULE6) brake overload warning before alarm, code high low high
// (RULE7) low encoder battery raises warning, code low low high
// (RULE8) changed restart parameter raises warning, code high high low
// (RULE9) undervoltage warning before alarm, code all low
// (RULE10) overtravel while powered raises warning, code high low low
// (RULE11) warning codes output only when code select equals one
// (RULE12) detect disable suppresses all warnings except undervoltage
// (RULE13) any phase low over one second with main power raises alarm
// (RULE14) system alarms go to panel only, never to history
// (RULE15) brake contactor answer disagreeing with command raises alarm
// (RULE16) host reads three pins as one pattern only when enabled
`timescale 1ns/1ps
module dwce_top import dwce_pkg::*; #(
	parameter int unsigned OPEN_PHASE_CYCLES = OPEN_PHASE_CYC,
	parameter int unsigned MISMATCH_CYCLES   = CONTACT_MISS_CYC
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [ERR_W-1:0] position_error,
	input  wire logic [ERR_W-1:0] excess_error_level,
	input  wire logic [PCT_W-1:0] excess_error_warn_percent,
	input  wire logic [ERR_W-1:0] servo_on_error_level,
	input  wire logic [PCT_W-1:0] servo_on_warn_percent,
	input  wire logic             code_output_select,
	input  wire logic             warning_detect_disable,
	input  wire logic             vibration_detect_switch,
	input  wire logic             motor_power_on,
	input  wire logic             overload_near,
	input  wire logic             vibration_detected,
	input  wire logic             regen_near,
	input  wire logic             brake_overload_near,
	input  wire logic             battery_low,
	input  wire logic             restart_param_changed,
	input  wire logic             undervolt_near,
	input  wire logic             overtravel_detected,
	input  wire logic             main_power_on,
	input  wire logic [2:0]       phase_low,
	input  wire logic             contactor_cmd,
	input  wire logic             contactor_answer,
	input  wire logic             system_fault_one,
	input  wire logic             system_fault_two,
	output logic                  code_out_bit_a,
	output logic                  code_out_bit_b,
	output logic                  code_out_bit_c,
	output logic                  warning_active,
	output logic                  vibration_alarm,
	output logic                  open_phase_alarm,
	output logic                  brake_contactor_alarm,
	output logic                  system_alarm_one,
	output logic                  system_alarm_two,
	output logic                  history_record
);
	// ====================================================================
	// three-flop synchronisers; change counts when stages two and three agree
	localparam int unsigned NS = 15;
	wire  logic [NS-1:0] raw = {system_fault_two, system_fault_one, contactor_answer, contactor_cmd,
		phase_low, main_power_on, overtravel_detected, undervolt_near, restart_param_changed,
		battery_low, brake_overload_near, regen_near, vibration_detected};
	logic [NS-1:0] s1, s2, s3, sy;
	logic [1:0]    p1, p2, p3, py;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1 <= '0; s2 <= '0; s3 <= '0; sy <= '0;
			p1 <= '0; p2 <= '0; p3 <= '0; py <= '0;
		end else begin
			s1 <= raw; s2 <= s1; s3 <= s2;
			sy <= (s2 & s3) | (sy & (s2 | s3));
			p1 <= {overload_near, motor_power_on}; p2 <= p1; p3 <= p2;
			py <= (p2 & p3) | (py & (p2 | p3));
		end
	end
	wire logic       y_vib   = sy[0];
	wire logic       y_regen = sy[1];
	wire logic       y_brk   = sy[2];
	wire logic       y_batt  = sy[3];
	wire logic       y_rst   = sy[4];
	wire logic       y_uv    = sy[5];
	wire logic       y_ot    = sy[6];
	wire logic       y_main  = sy[7];
	wire logic [2:0] y_phase = sy[10:8];
	wire logic       y_ccmd  = sy[11];
	wire logic       y_cans  = sy[12];
	wire logic       y_sys1  = sy[13];
	wire logic       y_sys2  = sy[14];
	wire logic       y_pwr   = py[0];
	wire logic       y_ovl   = py[1];
	// ====================================================================
	// position error limits, compared as err*100 > level*percent
	wire logic [ERR_W+PCT_W-1:0] err_x100  = position_error * (ERR_W+PCT_W)'(PCT_DIV);
	wire logic [ERR_W+PCT_W-1:0] lim_exc   = excess_error_level * (ERR_W+PCT_W)'(excess_error_warn_percent);
	wire logic [ERR_W+PCT_W-1:0] lim_son   = servo_on_error_level * (ERR_W+PCT_W)'(servo_on_warn_percent);
	wire logic en = (warning_detect_disable != DETECT_OFF);
	// (RULE1) excess error compare
	wire logic w_pos  = en & (err_x100 > lim_exc);
	// (RULE2) servo-on error compare
	wire logic w_son  = en & y_pwr & (err_x100 > lim_son);
	// (RULE3) overload ahead of alarm
	wire logic w_ovl  = en & y_ovl;
	// (RULE4) vibration routed by switch
	wire logic w_vib  = en & y_vib & ~vibration_detect_switch;
	wire logic a_vib  = y_vib & vibration_detect_switch;
	// (RULE5) regenerative overload warning
	wire logic w_reg  = en & y_regen;
	// (RULE6) brake overload warning
	wire logic w_brk  = en & y_brk;
	// (RULE7) battery low warning
	wire logic w_bat  = en & y_batt;
	// (RULE8) restart parameter warning
	wire logic w_rst  = en & y_rst;
	// (RULE12) undervoltage ignores disable
	wire logic w_uv   = y_uv;
	// (RULE10) overtravel while powered
	wire logic w_ot   = en & y_ot & y_pwr;
	wire logic any_w  = w_pos | w_son | w_ovl | w_vib | w_reg | w_brk | w_bat | w_rst | w_uv | w_ot;
	// ====================================================================
	// priority follows warning number order, lowest first
	logic [2:0] next_code;
	always_comb begin
		next_code = CODE_IDLE;
		if (w_pos | w_son)      next_code = CODE_POS_ERR;
		else if (w_ovl | w_vib) next_code = CODE_OVERLOAD;
		else if (w_reg | w_brk) next_code = CODE_REGEN_DB;
		else if (w_bat)         next_code = CODE_BATTERY;
		else if (w_rst)         next_code = CODE_RESTART;
		// (RULE9) undervoltage code all low
		else if (w_uv)          next_code = CODE_UNDERVOLT;
		else if (w_ot)          next_code = CODE_OVERTRAVEL;
	end
	// (RULE11) gate codes by select
	wire logic       show  = (code_output_select == SEL_WARN_CODES) & any_w;
	wire logic [2:0] shown = show ? next_code : CODE_IDLE;
	// ====================================================================
	// open phase timer; counts only with main power on and a phase low
	logic [31:0] op_cnt;
	wire  logic  op_cond = y_main & (|y_phase);
	// ====================================================================
	// contactor disagreement filter, masks normal switching time
	logic [15:0] cc_cnt;
	wire  logic  cc_miss = (y_ccmd != y_cans);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			op_cnt <= '0;
			cc_cnt <= '0;
		end else begin
			op_cnt <= op_cond ? ((op_cnt < OPEN_PHASE_CYCLES) ? op_cnt + 32'h1 : op_cnt) : '0;
			cc_cnt <= cc_miss ? ((cc_cnt < 16'(MISMATCH_CYCLES)) ? cc_cnt + 16'h1 : cc_cnt) : '0;
		end
	end
	// ====================================================================
	// outputs, all registered; alarms latch until reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{code_out_bit_a, code_out_bit_b, code_out_bit_c} <= CODE_RST;
			warning_active        <= 1'b0;
			vibration_alarm       <= 1'b0;
			open_phase_alarm      <= 1'b0;
			brake_contactor_alarm <= 1'b0;
			system_alarm_one      <= 1'b0;
			system_alarm_two      <= 1'b0;
			history_record        <= 1'b0;
		end else begin
			{code_out_bit_a, code_out_bit_b, code_out_bit_c} <= shown;
			warning_active        <= any_w;
			vibration_alarm       <= vibration_alarm | a_vib;
			// (RULE13) phase low over one second
			open_phase_alarm      <= open_phase_alarm | (op_cond & (op_cnt >= OPEN_PHASE_CYCLES));
			// (RULE15) answer disagrees with command
			brake_contactor_alarm <= brake_contactor_alarm | (cc_miss & (cc_cnt >= 16'(MISMATCH_CYCLES)));
			system_alarm_one      <= system_alarm_one | y_sys1;
			system_alarm_two      <= system_alarm_two | y_sys2;
			// (RULE14) system alarms kept out of history
			history_record        <= (a_vib & ~vibration_alarm)
				| (op_cond & (op_cnt >= OPEN_PHASE_CYCLES) & ~open_phase_alarm)
				| (cc_miss & (cc_cnt >= 16'(MISMATCH_CYCLES)) & ~brake_contactor_alarm);
		end
	end
	// ====================================================================
	// checks
	sequence s_sel_off;
		code_output_select != SEL_WARN_CODES;
	endsequence
	AST_SEL_GATE: assert property (@(posedge clk) disable iff (reset) // (RULE11)
		s_sel_off ##1 s_sel_off |-> {code_out_bit_a, code_out_bit_b, code_out_bit_c} == CODE_IDLE)
		else $error("code shown while select off");
	AST_POS_CODE: assert property (@(posedge clk) disable iff (reset) // (RULE1)
		(w_pos & show) |=> {code_out_bit_a, code_out_bit_b, code_out_bit_c} == CODE_POS_ERR)
		else $error("position error code wrong");
	AST_UV_CODE: assert property (@(posedge clk) disable iff (reset) // (RULE9)
		(w_uv & ~(w_pos|w_son|w_ovl|w_vib|w_reg|w_brk|w_bat|w_rst)) |=> ~code_out_bit_a & ~code_out_bit_b & ~code_out_bit_c)
		else $error("undervoltage code wrong");
	AST_DISABLE: assert property (@(posedge clk) disable iff (reset) // (RULE12)
		(warning_detect_disable & ~y_uv) |=> ~warning_active)
		else $error("warning seen while disabled");
	AST_OT_CODE: assert property (@(posedge clk) disable iff (reset) // (RULE10)
		(show & (next_code == CODE_OVERTRAVEL)) |-> y_pwr ##1 {code_out_bit_a, code_out_bit_b, code_out_bit_c} == 3'h4)
		else $error("overtravel code wrong");
	AST_OPEN_PH: assert property (@(posedge clk) disable iff (reset) // (RULE13)
		$rose(open_phase_alarm) |-> $past(op_cnt) >= OPEN_PHASE_CYCLES)
		else $error("open phase too early");
	AST_CONTACT: assert property (@(posedge clk) disable iff (reset) // (RULE15)
		$rose(brake_contactor_alarm) |-> $past(cc_miss))
		else $error("contactor alarm without mismatch");
	AST_SYS_HIST: assert property (@(posedge clk) disable iff (reset) // (RULE14)
		$rose(system_alarm_one) & ~$past(a_vib) & ~$past(op_cond) & ~$past(cc_miss) |-> ~history_record)
		else $error("system alarm recorded");
	AST_OVL_CODE: assert property (@(posedge clk) disable iff (reset) // (RULE3)
		(show & w_ovl & ~w_pos & ~w_son)
		|=> {code_out_bit_a, code_out_bit_b, code_out_bit_c} == CODE_OVERLOAD)
		else $error("overload code wrong");
	AST_VIB_ALARM: assert property (@(posedge clk) disable iff (reset) // (RULE4)
		(y_vib & vibration_detect_switch) |=> vibration_alarm & ~warning_active | vibration_alarm & any_w)
		else $error("vibration alarm not raised");
	AST_REGEN_CODE: assert property (@(posedge clk) disable iff (reset) // (RULE5)
		(show & w_reg & ~(w_pos | w_son | w_ovl | w_vib))
		|=> {code_out_bit_a, code_out_bit_b, code_out_bit_c} == CODE_REGEN_DB)
		else $error("regenerative code wrong");
	AST_BATT_CODE: assert property (@(posedge clk) disable iff (reset) // (RULE7)
		(show & w_bat & ~(w_pos | w_son | w_ovl | w_vib | w_reg | w_brk))
		|=> {code_out_bit_a, code_out_bit_b, code_out_bit_c} == CODE_BATTERY)
		else $error("battery code wrong");
endmodule : dwce_top

// file: dwce_top_tb.sv
// testbench for the drive warning code encoder
// assumes a short open phase count and the host model beside it
`timescale 1ns/1ps
module dwce_top_tb import dwce_pkg::*;;
	logic clk = 0, reset = 1, sel = 1, dis = 0, vsw = 0;
	logic [15:0] cond = 16'h0001;
	logic [2:0] ph = 3'h0, pat;
	logic [ERR_W-1:0] perr = 32'h0, elev = 32'h3e8, slev = 32'h7d0;
	logic [PCT_W-1:0] epct = 8'h32, spct = 8'h64;
	logic a, b, c, wact, pval, vib_al, op_al, bc_al, s1, s2, hist;
	int miscompares = 0, checks_done = 0, cyc = 0, hist_n = 0, h0;
	initial forever #25 clk = ~clk;
	dwce_top #(.OPEN_PHASE_CYCLES(50), .MISMATCH_CYCLES(16)) dut_u (.clk(clk), .reset(reset),
		.position_error(perr), .excess_error_level(elev), .excess_error_warn_percent(epct),
		.servo_on_error_level(slev), .servo_on_warn_percent(spct), .code_output_select(sel),
		.warning_detect_disable(dis), .vibration_detect_switch(vsw), .motor_power_on(cond[0]),
		.overload_near(cond[1]), .vibration_detected(cond[2]), .regen_near(cond[3]),
		.brake_overload_near(cond[4]), .battery_low(cond[5]), .restart_param_changed(cond[6]),
		.undervolt_near(cond[7]), .overtravel_detected(cond[8]), .main_power_on(cond[9]),
		.phase_low(ph), .contactor_cmd(cond[10]), .contactor_answer(cond[11]),
		.system_fault_one(cond[12]), .system_fault_two(cond[13]), .code_out_bit_a(a),
		.code_out_bit_b(b), .code_out_bit_c(c), .warning_active(wact), .vibration_alarm(vib_al),
		.open_phase_alarm(op_al), .brake_contactor_alarm(bc_al), .system_alarm_one(s1),
		.system_alarm_two(s2), .history_record(hist));
	dwce_host host_u (.code_out_bit_a(a), .code_out_bit_b(b), .code_out_bit_c(c),
		.code_output_select(sel), .warning_active(wact), .pattern(pat), .pattern_valid(pval));
	// ====================================================================
	// checking and closing
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// counted off the falling edge, half a cycle after the launching edge, so each pulse is seen settled
	always @(negedge clk) begin
		cyc++;
		if (hist === 1'b1)
			hist_n++;
		if (cyc == 4000) begin
			miscompares++;
			stop_test();
		end
	end
	// ====================================================================
	// one condition on, wait for detection, read the host pattern
	task automatic warn(input int idx, input logic [2:0] exp, input logic act);
		@(negedge clk);
		cond = 16'h0001 | (16'h0001 << idx);
		repeat (12) @(negedge clk);
		check("warning_active", {31'h0, act}, {31'h0, wact});
		check("code", {29'h0, exp}, {29'h0, pat});
		check("pattern_valid", {31'h0, sel & act}, {31'h0, pval});
		cond = 16'h0001;
		perr = 32'h0;
		repeat (8) @(negedge clk);
	endtask : warn
	initial begin
		repeat (20) @(negedge clk);
		reset = 0;
		warn(5, CODE_BATTERY, 1'b1);
		warn(6, CODE_RESTART, 1'b1);
		warn(8, CODE_OVERTRAVEL, 1'b1);
		warn(3, CODE_REGEN_DB, 1'b1);
		warn(4, CODE_REGEN_DB, 1'b1);
		warn(1, CODE_OVERLOAD, 1'b1);
		warn(2, CODE_OVERLOAD, 1'b1);
		warn(7, CODE_UNDERVOLT, 1'b1);
		perr = 32'h1f4;
		warn(15, 3'h0, 1'b0);
		perr = 32'h1f5;
		warn(15, CODE_POS_ERR, 1'b1);
		epct = 8'h64;
		spct = 8'h0a;
		perr = 32'h12c;
		warn(15, CODE_POS_ERR, 1'b1);
		// no motor power: servo-on error and overtravel stay silent
		perr = 32'h12c;
		cond = 16'h0100;
		repeat (12) @(negedge clk);
		check("unpowered_warning", 32'h0, {31'h0, wact});
		check("unpowered_code", 32'h0, {29'h0, pat});
		cond = 16'h0001;
		perr = 32'h0;
		repeat (8) @(negedge clk);
		sel = 0;
		warn(5, 3'h0, 1'b1);
		sel = 1;
		dis = 1;
		warn(5, 3'h0, 1'b0);
		warn(7, CODE_UNDERVOLT, 1'b1);
		dis = 0;
		vsw = 1;
		warn(2, 3'h0, 1'b0);
		check("vibration_alarm", 32'h1, {31'h0, vib_al});
		// a short dip must not count as an open phase
		cond = 16'h0201;
		ph = 3'h2;
		repeat (30) @(negedge clk);
		ph = 3'h0;
		repeat (10) @(negedge clk);
		check("open_phase_early", 32'h0, {31'h0, op_al});
		h0 = hist_n;
		ph = 3'h2;
		repeat (70) @(negedge clk);
		check("open_phase_alarm", 32'h1, {31'h0, op_al});
		check("history_pulses", h0 + 1, hist_n);
		cond = 16'h0c01;
		repeat (30) @(negedge clk);
		check("contactor_agree", 32'h0, {31'h0, bc_al});
		cond = 16'h0401;
		repeat (30) @(negedge clk);
		check("contactor_alarm", 32'h1, {31'h0, bc_al});
		h0 = hist_n;
		cond = 16'h3001;
		repeat (12) @(negedge clk);
		check("system_alarms", 32'h3, {30'h0, s1, s2});
		check("history_pulses", h0, hist_n);
		stop_test();
	end
endmodule : dwce_top_tb
